/* include/rpc_pkg.sv */
// constants for reset-time mode, pin configuration and emulation support
package rpc_pkg;
    // operating mode, gray coded along single -> 16-bit -> 8-bit
    typedef enum logic [1:0] {
        RPC_MODE_SINGLE = 2'h0,
        RPC_MODE_EXP16 = 2'h1,
        RPC_MODE_EXP8 = 2'h3
    } rpc_mode_t;

    // software register indices
    localparam logic [3:0] RPC_REG_MODE = 4'h0;
    localparam logic [3:0] RPC_REG_CTRL = 4'h1;
    localparam logic [3:0] RPC_REG_STRAP = 4'h2;

    // control register
    localparam int RPC_CTRL_STOP_SHADOW = 0;
    localparam logic RPC_CTRL_STOP_SHADOW_RST = 1'h0;

    // mode register fields
    localparam int RPC_MD_MODE_LO = 0;
    localparam int RPC_MD_EMU = 2;
    localparam int RPC_MD_ROM_EMU = 3;
    localparam int RPC_MD_SYNTH = 4;
    localparam int RPC_MD_FLASH_STOP = 5;
    localparam int RPC_MD_BKGND = 6;
    localparam int RPC_MD_PORT_E = 7;
    localparam int RPC_MD_PORT_F = 8;

    // captured strap vector positions
    localparam int RPC_ST_BUS_ERR = 0;
    localparam int RPC_ST_WIDTH = 1;
    localparam int RPC_ST_BUS_CTRL = 2;
    localparam int RPC_ST_INTR = 3;
    localparam int RPC_ST_EMUL = 4;
    localparam int RPC_ST_RSVD = 5;
    localparam int RPC_ST_ROM = 6;
    localparam int RPC_ST_FSTOP = 7;
    localparam int RPC_ST_CLK = 8;
    localparam int RPC_ST_BREAKPOINT_STRAP = 9;
    localparam int RPC_ST_W = 10;
    // straps as they read with no drive (pulled up)
    localparam logic [RPC_ST_W-1:0] RPC_STRAP_RST = 10'h3FF;

    // port register block and offsets
    localparam logic [15:0] RPC_PORT_BASE = 16'hFFFA;
    localparam logic [7:0] RPC_OFS_PORTA = 8'h00;
    localparam logic [7:0] RPC_OFS_PORTB = 8'h01;
    localparam logic [7:0] RPC_OFS_DDRA = 8'h02;
    localparam logic [7:0] RPC_OFS_DDRB = 8'h03;
    localparam logic [7:0] RPC_OFS_PORTE = 8'h04;
    localparam logic [7:0] RPC_OFS_DDRE = 8'h05;
    localparam logic [7:0] RPC_OFS_PEPAR = 8'h06;
    localparam logic [7:0] RPC_OFS_PORTG = 8'h08;
    localparam logic [7:0] RPC_OFS_PORTH = 8'h09;
    localparam logic [7:0] RPC_OFS_DDRG = 8'h0A;
    localparam logic [7:0] RPC_OFS_DDRH = 8'h0B;
    localparam logic [7:0] RPC_OFS_PORTC = 8'h10;
    localparam logic [7:0] RPC_OFS_PORTF = 8'h11;
    localparam logic [7:0] RPC_OFS_DDRF = 8'h12;
    localparam logic [7:0] RPC_OFS_PFPAR = 8'h13;

    // internal rom array window
    localparam logic [23:0] RPC_ROM_BASE = 24'hFF0000;
    localparam logic [23:0] RPC_ROM_MASK = 24'hFF0000;

    // externally mapped port access length in system clocks
    localparam int RPC_EXT_ACC_CYC = 3;
    localparam logic [1:0] RPC_EXT_ACC_LAST = 2'(RPC_EXT_ACC_CYC - 1);
endpackage : rpc_pkg

/* logic/rpc_addr_class.sv */
// classifies an access address against the port register block
`timescale 1ns/1ps
module rpc_addr_class
    import rpc_pkg::*;
(
    input wire logic [23:0] addr,
    output logic ext_hit,
    output logic int_hit,
    output logic rom_hit
);
    logic [7:0] ofs;
    logic in_blk;
    logic ext_ofs;
    logic int_ofs;

    assign ofs = addr[7:0];
    assign in_blk = addr[23:8] == RPC_PORT_BASE;
    assign ext_ofs = ofs == RPC_OFS_PORTA || ofs == RPC_OFS_PORTB ||
                     ofs == RPC_OFS_DDRA || ofs == RPC_OFS_DDRB ||
                     ofs == RPC_OFS_PORTE || ofs == RPC_OFS_DDRE ||
                     ofs == RPC_OFS_PEPAR || ofs == RPC_OFS_PORTG ||
                     ofs == RPC_OFS_PORTH || ofs == RPC_OFS_DDRG ||
                     ofs == RPC_OFS_DDRH;
    assign int_ofs = ofs == RPC_OFS_PORTC || ofs == RPC_OFS_PORTF ||
                     ofs == RPC_OFS_DDRF || ofs == RPC_OFS_PFPAR;
    assign ext_hit = in_blk && ext_ofs;
    assign int_hit = in_blk && int_ofs;
    assign rom_hit = (addr & RPC_ROM_MASK) == RPC_ROM_BASE;
endmodule : rpc_addr_class

/* logic/rpc_mode_config.sv */
// reset strap capture, mode and pin function selection, emulation selects
//
// Notes on behaviour
// - 8-bit expanded: low byte port, high data
// - 8-bit expanded never enables emulator mode
// - bus control strap low selects port E
// - 8-bit expanded: chip-select group fixed function
// - bus error low: single chip, ports A/B/G/H
// - single chip ignores port and emulation straps, all ports
// - emulator mode maps port registers externally
// - port C and F registers stay internal
// - emulator select on externally mapped access
// - emulator select at address strobe fall
// - mapped accesses terminated by outside logic
// - mapped access lasts three system clocks
// - rom select on valid rom access
// - rom emulation forces external bus cycles
// - rom select stays high on this variant
// - clock strap high selects synthesizer
// - clock strap low disables synthesizer
// - flash stop from strap or shadow bit
// - mode from bus error and width only
// - undriven data straps give default function
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module rpc_mode_config
    import rpc_pkg::*;
#(
    // flash modules here cannot serve rom emulation
    parameter bit ROM_EMUL_SUPPORT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic bus_error_strap,
    input wire logic width_select_strap,
    input wire logic bus_ctrl_port_strap,
    input wire logic intr_port_strap,
    input wire logic emulation_strap,
    input wire logic reserved_strap_high,
    input wire logic rom_emul_strap,
    input wire logic flash_stop_strap,
    input wire logic clock_mode_strap,
    input wire logic breakpoint_strap,
    input wire logic [23:0] acc_addr,
    input wire logic address_strobe_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output rpc_mode_t op_mode,
    output logic addr_bus_en,
    output logic data_hi_bus_en,
    output logic data_lo_bus_en,
    output logic port_a_en,
    output logic port_b_en,
    output logic port_c_en,
    output logic port_e_en,
    output logic port_f_en,
    output logic port_g_en,
    output logic port_h_en,
    output logic cs_fixed_func,
    output logic emulator_mode,
    output logic rom_emul_en,
    output logic synth_en,
    output logic bkgnd_en,
    output logic flash_stop,
    output logic emulator_port_select_n,
    output logic rom_emulation_select_n,
    output logic int_term_inhibit
);
    logic [RPC_ST_W-1:0] strap_r;
    logic [RPC_ST_W-1:0] strap_nxt;
    logic stop_shadow_r;
    logic as_prev_r;
    logic [1:0] acc_cnt_r;
    logic [1:0] acc_cnt_nxt;
    logic cse_nxt;
    logic ext_hit;
    logic int_hit;
    logic rom_hit;
    logic as_fall;
    logic as_low;
    rpc_mode_t mode_nxt;
    logic single;
    logic expanded;
    logic emu_nxt;
    logic rom_emu_nxt;
    logic [15:0] mode_word;
    logic [15:0] rd_mux;
    logic sel_mode;
    logic sel_ctrl;
    logic sel_strap;

    rpc_addr_class u_class (
        .addr(acc_addr),
        .ext_hit(ext_hit),
        .int_hit(int_hit),
        .rom_hit(rom_hit)
    );

    // strap latch
    // straps follow the pins while reset is low, frozen at release
    assign strap_nxt = {breakpoint_strap, clock_mode_strap,
                        flash_stop_strap, rom_emul_strap,
                        reserved_strap_high, emulation_strap,
                        intr_port_strap, bus_ctrl_port_strap,
                        width_select_strap, bus_error_strap};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            strap_r <= strap_nxt;
        end
    end

    always_comb begin
        case ({strap_r[RPC_ST_BUS_ERR], strap_r[RPC_ST_WIDTH]})
            2'b10: mode_nxt = RPC_MODE_EXP16;
            2'b11: mode_nxt = RPC_MODE_EXP8;
            default: mode_nxt = RPC_MODE_SINGLE;
        endcase
    end

    assign single = mode_nxt == RPC_MODE_SINGLE;
    assign expanded = !single;
    assign emu_nxt = mode_nxt == RPC_MODE_EXP16 && !strap_r[RPC_ST_EMUL];
    assign rom_emu_nxt = emu_nxt && !strap_r[RPC_ST_ROM];

    // default on high
    // a high strap is the pulled-up default, low picks the alternate
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            op_mode <= RPC_MODE_SINGLE;
            addr_bus_en <= 1'b0;
            data_hi_bus_en <= 1'b0;
            data_lo_bus_en <= 1'b0;
            port_a_en <= 1'b0;
            port_b_en <= 1'b0;
            port_c_en <= 1'b0;
            port_e_en <= 1'b0;
            port_f_en <= 1'b0;
            port_g_en <= 1'b0;
            port_h_en <= 1'b0;
            cs_fixed_func <= 1'b0;
            emulator_mode <= 1'b0;
            rom_emul_en <= 1'b0;
            synth_en <= 1'b0;
            bkgnd_en <= 1'b0;
        end else begin
            op_mode <= mode_nxt;
            addr_bus_en <= expanded;
            data_hi_bus_en <= expanded;
            data_lo_bus_en <= mode_nxt == RPC_MODE_EXP16;
            port_a_en <= single;
            port_b_en <= single;
            port_g_en <= single;
            port_h_en <= mode_nxt != RPC_MODE_EXP16;
            port_c_en <= single;
            port_e_en <= single || !strap_r[RPC_ST_BUS_CTRL];
            port_f_en <= single || !strap_r[RPC_ST_INTR];
            cs_fixed_func <= mode_nxt == RPC_MODE_EXP8;
            emulator_mode <= emu_nxt;
            rom_emul_en <= rom_emu_nxt;
            synth_en <= strap_r[RPC_ST_CLK];
            bkgnd_en <= !strap_r[RPC_ST_BREAKPOINT_STRAP];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flash_stop <= 1'b0;
        end else begin
            flash_stop <= !strap_r[RPC_ST_FSTOP] || stop_shadow_r;
        end
    end

    // register port decode
    assign sel_mode = reg_addr == RPC_REG_MODE;
    assign sel_ctrl = reg_addr == RPC_REG_CTRL;
    assign sel_strap = reg_addr == RPC_REG_STRAP;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stop_shadow_r <= RPC_CTRL_STOP_SHADOW_RST;
        end else if (reg_wr && sel_ctrl) begin
            stop_shadow_r <= reg_wdata[RPC_CTRL_STOP_SHADOW];
        end
    end

    always_comb begin
        mode_word = 16'h0000;
        mode_word[RPC_MD_MODE_LO +: 2] = op_mode;
        mode_word[RPC_MD_EMU] = emulator_mode;
        mode_word[RPC_MD_ROM_EMU] = rom_emul_en;
        mode_word[RPC_MD_SYNTH] = synth_en;
        mode_word[RPC_MD_FLASH_STOP] = flash_stop;
        mode_word[RPC_MD_BKGND] = bkgnd_en;
        mode_word[RPC_MD_PORT_E] = port_e_en;
        mode_word[RPC_MD_PORT_F] = port_f_en;
    end

    // reserved strap visible
    // a low reserved strap shows as a clear bit in the strap word
    assign rd_mux = sel_mode ? mode_word :
                    sel_ctrl ? {15'h0000, stop_shadow_r} :
                    sel_strap ? {6'h00, strap_r} : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // emulator access tracking
    assign as_fall = as_prev_r && !address_strobe_n;
    assign as_low = !address_strobe_n;

    always_comb begin
        acc_cnt_nxt = acc_cnt_r;
        cse_nxt = emulator_port_select_n;
        if (!emulator_port_select_n) begin
            if (acc_cnt_r == RPC_EXT_ACC_LAST) begin
                cse_nxt = 1'b1;
                acc_cnt_nxt = 2'h0;
            end else begin
                acc_cnt_nxt = 2'(acc_cnt_r + 2'h1);
            end
        end else if (emulator_mode && as_fall && ext_hit && !int_hit) begin
            cse_nxt = 1'b0;
            acc_cnt_nxt = 2'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            as_prev_r <= 1'b1;
            acc_cnt_r <= 2'h0;
            emulator_port_select_n <= 1'b1;
        end else begin
            as_prev_r <= address_strobe_n;
            acc_cnt_r <= acc_cnt_nxt;
            emulator_port_select_n <= cse_nxt;
        end
    end

    // select held high
    // without flash support the rom select never leaves its idle level
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            int_term_inhibit <= 1'b0;
            rom_emulation_select_n <= 1'b1;
        end else begin
            int_term_inhibit <= as_low &&
                ((emulator_mode && ext_hit) || (rom_emul_en && rom_hit));
            rom_emulation_select_n <= !(ROM_EMUL_SUPPORT && rom_emul_en &&
                                        as_low && rom_hit);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_mapped_fall;
        emulator_mode && as_fall && ext_hit && emulator_port_select_n;
    endsequence

    sequence s_cse_pulse;
        !emulator_port_select_n [*3] ##1 emulator_port_select_n;
    endsequence

    a_exp8_emu_off: assert property (op_mode == RPC_MODE_EXP8 |->
        !emulator_mode && !rom_emul_en)
        else $error("emulator mode on in 8-bit expanded");
    a_exp8_lo_port: assert property ($past(rst_b) &&
        op_mode == RPC_MODE_EXP8 |-> port_h_en && data_hi_bus_en &&
        !data_lo_bus_en && cs_fixed_func)
        else $error("8-bit expanded pin set wrong");
    a_single_ports: assert property ($past(rst_b) &&
        op_mode == RPC_MODE_SINGLE |-> port_a_en && port_b_en &&
        port_g_en && port_h_en && port_c_en && port_e_en && port_f_en &&
        !addr_bus_en)
        else $error("single chip ports not selected");
    // first edge after release loads the outputs, so look two edges back
    a_mode_held: assert property ($past(rst_b, 2) && $past(rst_b) |->
        $stable(op_mode) && $stable(synth_en) && $stable(strap_r))
        else $error("mode changed outside reset");
    a_cse_on_fall: assert property (s_mapped_fall |=>
        s_cse_pulse)
        else $error("emulator select not three clocks after strobe fall");
    a_cse_cause: assert property ($fell(emulator_port_select_n) |->
        $past(emulator_mode && as_fall && ext_hit))
        else $error("emulator select without mapped access");
    a_cse_quiet: assert property (!emulator_mode |->
        emulator_port_select_n)
        else $error("emulator select outside emulator mode");
    a_rom_sel_high: assert property (!ROM_EMUL_SUPPORT |->
        rom_emulation_select_n)
        else $error("rom select driven low");
    a_flash_stop: assert property ($past(rst_b) |->
        flash_stop == ($past(!strap_r[RPC_ST_FSTOP]) ||
        $past(stop_shadow_r)))
        else $error("flash stop mismatch");
    a_rom_ext_cycle: assert property (rom_emul_en && as_low &&
        rom_hit |=> int_term_inhibit)
        else $error("rom access not sent external");
    // outside logic must end mapped cycles, so the inhibit has to be up
    a_ext_inhibit: assert property (emulator_mode && as_low &&
        ext_hit |=> int_term_inhibit)
        else $error("mapped access not left to outside logic");
    a_int_quiet: assert property (emulator_port_select_n &&
        !ext_hit |=> emulator_port_select_n)
        else $error("emulator select on internal register");
    a_single_no_bus: assert property (op_mode == RPC_MODE_SINGLE |->
        !data_hi_bus_en && !data_lo_bus_en && !emulator_mode &&
        !rom_emul_en)
        else $error("bus or emulation enabled in single chip");
endmodule : rpc_mode_config

/* dv/rpc_pru_model.sv */
// strap driver and port replacement responder facing the mode block
`timescale 1ns/1ps
module rpc_pru_model
    import rpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [RPC_ST_W-1:0] cfg,
    input wire logic emulator_port_select_n,
    output logic [RPC_ST_W-1:0] straps,
    output logic [7:0] sel_cnt
);
    // released lines flip, so a missed latch cannot hide
    assign straps = rst_b ? ~cfg : cfg;

    // mapped cycles answered here, length counted
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sel_cnt <= 8'h00;
        end else if (!emulator_port_select_n) begin
            sel_cnt <= sel_cnt + 8'h01;
        end
    end
endmodule : rpc_pru_model

/* dv/reset_mode_pin_config_emulation_tb.sv */
// self-checking bench for strap capture, mode decode and emulation selects
`timescale 1ns/1ps
module reset_mode_pin_config_emulation_tb;
    import rpc_pkg::*;
    typedef struct {
        logic [9:0] cfg;
        logic [17:0] exp;
    } rpc_row_t;
    logic ref_clk, rst_b, address_strobe_n, reg_wr, reg_rd;
    logic [9:0] cfg, straps;
    logic [23:0] acc_addr;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0] sel_cnt;
    rpc_mode_t op_mode;
    logic addr_bus_en, port_e_en, port_h_en, emulator_mode, rom_emul_en;
    logic synth_en, bkgnd_en, flash_stop, sel_n, rom_sel_n, inhibit;
    logic data_hi_bus_en, data_lo_bus_en, port_a_en, port_b_en, port_c_en;
    logic port_f_en, port_g_en, cs_fixed_func;
    logic [17:0] outs;
    int err_count, n_tests;
    rpc_row_t rows [6];
    logic [7:0] ext_ofs [4];
    logic [7:0] int_ofs [2];

    assign outs = {data_hi_bus_en, data_lo_bus_en, port_a_en, port_b_en,
                   port_c_en, port_f_en, port_g_en, cs_fixed_func,
                   op_mode, emulator_mode, rom_emul_en, synth_en, flash_stop,
                   bkgnd_en, port_e_en, port_h_en, addr_bus_en};

    rpc_mode_config i_rpc_mode_config (.ref_clk(ref_clk), .rst_b(rst_b),
        .bus_error_strap(straps[RPC_ST_BUS_ERR]),
        .width_select_strap(straps[RPC_ST_WIDTH]),
        .bus_ctrl_port_strap(straps[RPC_ST_BUS_CTRL]),
        .intr_port_strap(straps[RPC_ST_INTR]),
        .emulation_strap(straps[RPC_ST_EMUL]),
        .reserved_strap_high(straps[RPC_ST_RSVD]),
        .rom_emul_strap(straps[RPC_ST_ROM]),
        .flash_stop_strap(straps[RPC_ST_FSTOP]),
        .clock_mode_strap(straps[RPC_ST_CLK]),
        .breakpoint_strap(straps[RPC_ST_BREAKPOINT_STRAP]),
        .acc_addr(acc_addr), .address_strobe_n(address_strobe_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_mode(op_mode),
        .addr_bus_en(addr_bus_en), .data_hi_bus_en(data_hi_bus_en),
        .data_lo_bus_en(data_lo_bus_en), .port_a_en(port_a_en),
        .port_b_en(port_b_en), .port_c_en(port_c_en), .port_e_en(port_e_en),
        .port_f_en(port_f_en), .port_g_en(port_g_en), .port_h_en(port_h_en),
        .cs_fixed_func(cs_fixed_func), .emulator_mode(emulator_mode),
        .rom_emul_en(rom_emul_en), .synth_en(synth_en), .bkgnd_en(bkgnd_en),
        .flash_stop(flash_stop), .emulator_port_select_n(sel_n),
        .rom_emulation_select_n(rom_sel_n), .int_term_inhibit(inhibit));

    rpc_pru_model i_rpc_pru_model (.ref_clk(ref_clk), .rst_b(rst_b),
        .cfg(cfg), .emulator_port_select_n(sel_n), .straps(straps),
        .sel_cnt(sel_cnt));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset(input logic [9:0] c);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        cfg <= c;
        repeat (10) @(posedge ref_clk);
        #1;
        chk(16'(op_mode), 16'h0000);
        chk(16'(sel_n), 16'h0001);
        @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    // strobe held well past the pulse; only one select pulse may result
    task automatic access(input logic [23:0] a, input logic [7:0] n,
                          input logic inh);
        logic [7:0] c0;
        logic seen;
        c0 = sel_cnt;
        seen = 1'b0;
        @(posedge ref_clk);
        address_strobe_n <= 1'b0;
        acc_addr <= a;
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            seen = seen | inhibit;
            chk(16'(rom_sel_n), 16'h0001);
        end
        @(posedge ref_clk);
        address_strobe_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(16'(8'(sel_cnt - c0)), 16'(n));
        chk(16'(seen), 16'(inh));
    endtask : access

    initial begin
        #400000;
        err_count++;
        give_verdict();
    end

    initial begin
        rst_b = 1'b0;
        cfg = 10'h3FF;
        address_strobe_n = 1'b1;
        acc_addr = 24'h000000;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        n_tests = 0;
        rows = '{'{10'h3FF, 18'h20723}, '{10'h023, 18'h2171F},
                 '{10'h3FD, 18'h30121}, '{10'h3ED, 18'h301A1},
                 '{10'h3AD, 18'h301E1}, '{10'h3EC, 18'h0F826}};
        ext_ofs = '{RPC_OFS_PORTA, RPC_OFS_PEPAR, RPC_OFS_PORTG, RPC_OFS_DDRH};
        int_ofs = '{RPC_OFS_PORTC, RPC_OFS_PFPAR};
        for (int i = 0; i < 6; i++) begin
            do_reset(rows[i].cfg);
            repeat (3) @(posedge ref_clk);
            #1;
            chk(32'(outs), 32'(rows[i].exp));
            rd(RPC_REG_STRAP, {6'h00, rows[i].cfg});
            $display("mode row %0d done", i);
        end
        do_reset(10'h3ED);
        foreach (ext_ofs[k]) begin
            access({RPC_PORT_BASE, ext_ofs[k]}, 8'h03, 1'b1);
        end
        foreach (int_ofs[k]) begin
            access({RPC_PORT_BASE, int_ofs[k]}, 8'h00, 1'b0);
        end
        $display("emulator mapping done");
        do_reset(10'h3FF);
        access({RPC_PORT_BASE, RPC_OFS_PORTA}, 8'h00, 1'b0);
        do_reset(10'h3AD);
        access(24'hFF1234, 8'h00, 1'b1);
        $display("rom emulation done");
        do_reset(10'h3FF);
        wr(RPC_REG_CTRL, 16'h0001);
        rd(RPC_REG_CTRL, 16'h0001);
        chk(16'(flash_stop), 16'h0001);
        wr(RPC_REG_STRAP, 16'h0000);
        rd(RPC_REG_STRAP, 16'h03FF);
        rd(4'hF, 16'h0000);
        $display("register port done");
        give_verdict();
    end
endmodule : reset_mode_pin_config_emulation_tb
